/* scp_config_port.sv */
// Functional notes
// - Clock input held off 2 ms after reset.
// - Divider reset value taken from strap pin.
// - Clock outputs on, sysref outputs off initially.
// - Ready flag set when power-up completes.
// - Align command starts alignment, then self-clears.
// - Pending flag high while waiting or aligning.
// - Powerdown pulse in AC-coupled mode parks sysref legs at crosspoint.
// - Calibration commands start calibrations, then self-clear.
// - Init command resyncs dividers, holds outputs low.
// - Output enables live in two registers.
// - Sysref delay changes never stop outputs.
// - Deselected: data line released, port idle.
// - Input bits sampled on rising serial clock.
// - Read edge chosen by polarity bit.
// - First byte: direction then address, LSB first.
// - Read: line turns output, register shifted out.
// - Continued reads walk successive addresses.
// - Write stores each byte below the reserved range, address auto-increments.
`timescale 1ns/1ps
`default_nettype none
module scp_config_port
#(
	parameter int STARTUP_CNT = scp_pkg::STARTUP_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic select_low,
	input wire logic sclk,
	input wire logic serial_data_i,
	output logic serial_data_o,
	output logic serial_data_oe,
	input wire logic divider_default_pin,
	input wire logic sysref_ref_in,
	output logic clock_input_enable,
	output logic power_up_done_flag,
	output logic align_pending_flag,
	output logic [scp_pkg::DATA_W-1:0] clock_output_en,
	output logic [scp_pkg::DATA_W-1:0] sysref_output_en,
	output logic outputs_hold_low,
	output logic sysref_park_vos,
	output logic bias_cal_start,
	output logic delay_cal_start,
	output logic clk_init_start,
	output logic [scp_pkg::DATA_W-1:0] divider_setting,
	output logic [scp_pkg::DATA_W-1:0] sysref_delay
);
	import scp_pkg::*;

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	logic sclk_prev_q; // Serial clock level one cycle ago.
	logic ref_prev_q; // Reference input level one cycle ago.
	logic [2:0] bit_cnt_q; // Bit position within the current byte.
	logic cmd_phase_q; // High while the command byte is arriving.
	logic dir_read_q; // Direction of the current transfer.
	logic [ADDR_W-1:0] addr_q; // Current register address.
	logic [DATA_W-1:0] rx_sh_q; // Receive shift register.
	logic [DATA_W-1:0] tx_sh_q; // Transmit shift register.
	logic fetch_q; // Read data from storage arrive this cycle.
	logic [ADDR_W-1:0] fetch_addr_q; // Address of the fetched byte.
	logic wr_en_q; // One-cycle write strobe.
	logic [ADDR_W-1:0] wr_addr_q; // Address of the write.
	logic [DATA_W-1:0] wr_data_q; // Data of the write.
	logic [STARTUP_CNT_W-1:0] start_cnt_q; // Startup hold-off counter.
	logic strap_done_q; // Strap pin already captured.
	logic [DATA_W-1:0] oe_a_q; // Clock output enables.
	logic [DATA_W-1:0] oe_b_q; // Sysref output enables.
	logic [DATA_W-1:0] config_q; // Polarity, bias type and powerdown.
	logic [7:0] init_cnt_q; // Remaining cycles of the init step.
	logic [7:0] align_cnt_q; // Remaining cycles of the alignment run.
	scp_align_e align_state_q; // Alignment sequencer state.
	logic [DATA_W-1:0] mem_rd_data; // Registered storage read data.
	logic [ADDR_W-1:0] rd_addr_c; // Address presented to storage.
	logic [DATA_W-1:0] rx_next; // Receive register after this bit.
	logic sclk_rise; // Rising edge of the serial clock.
	logic sclk_fall; // Falling edge of the serial clock.
	logic out_edge; // Edge on which read data change.
	logic byte_done; // Last bit of a byte taken this cycle.
	logic ref_rise; // Rising edge on the reference input.
	logic cmd_wr; // Write to the command register.
	logic [DATA_W-1:0] read_value; // Byte returned by a read.

	// Decides whether an address belongs to the dedicated control registers.
	function automatic logic scp_is_dedicated(input logic [ADDR_W-1:0] a);
		scp_is_dedicated = (a == REG_DIVIDER) || (a == REG_STATUS) ||
			(a == REG_COMMAND) || (a == REG_CONFIG) ||
			(a == REG_SYSREF_DELAY) || (a == REG_OE_A) || (a == REG_OE_B);
	endfunction

	// -------------------------------------------------------------------------
	// Edge detection and decoding
	// -------------------------------------------------------------------------

	// Pins are synchronous to clk, so edges come from a one-cycle delay.
	assign sclk_rise = sclk && !sclk_prev_q;
	assign sclk_fall = !sclk && sclk_prev_q;
	assign ref_rise = sysref_ref_in && !ref_prev_q;
	assign rx_next = {serial_data_i, rx_sh_q[DATA_W-1:1]};
	assign byte_done = sclk_rise && !select_low && (bit_cnt_q == LAST_BIT);
	assign out_edge = config_q[CFG_READ_POL_BIT] ? sclk_rise : sclk_fall;
	assign cmd_wr = wr_en_q && (wr_addr_q == REG_COMMAND);

	// Storage is addressed by the byte that is about to be read out.
	always_comb
	begin
		rd_addr_c = addr_q;
		if (byte_done && cmd_phase_q)
		begin
			rd_addr_c = rx_next[DATA_W-1:1];
		end
		else if (byte_done && dir_read_q)
		begin
			rd_addr_c = addr_q + 7'h01;
		end
	end

	// Readback mux; command bits always read as zero.
	always_comb
	begin
		read_value = mem_rd_data;
		case (fetch_addr_q)
			REG_DIVIDER: read_value = divider_setting;
			REG_STATUS:
			begin
				read_value = 8'h00;
				read_value[POWER_UP_DONE_FLAG_BIT] = power_up_done_flag;
				read_value[ST_ALIGN_BIT] = align_pending_flag;
			end
			REG_COMMAND: read_value = 8'h00;
			REG_CONFIG: read_value = config_q;
			REG_SYSREF_DELAY: read_value = sysref_delay;
			REG_OE_A: read_value = oe_a_q;
			REG_OE_B: read_value = oe_b_q;
			default: read_value = scp_is_dedicated(fetch_addr_q) ? 8'h00 : mem_rd_data;
		endcase
	end

	// Sampling registers for the edge detectors.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_prev_q <= 1'b0;
			ref_prev_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q <= sclk;
			ref_prev_q <= sysref_ref_in;
		end
	end

	// -------------------------------------------------------------------------
	// Serial receive and command decoding
	// -------------------------------------------------------------------------

	// Bits and bytes are counted on rising serial clock edges only.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bit_cnt_q <= 3'h0;
			cmd_phase_q <= 1'b1;
			dir_read_q <= 1'b0;
			addr_q <= 7'h00;
			rx_sh_q <= 8'h00;
			wr_en_q <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
		end
		else
		begin
			wr_en_q <= 1'b0;
			if (select_low)
			begin
				bit_cnt_q <= 3'h0;
				cmd_phase_q <= 1'b1;
			end
			else if (sclk_rise)
			begin
				rx_sh_q <= rx_next;
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (byte_done && cmd_phase_q)
				begin
					dir_read_q <= rx_next[0];
					addr_q <= rx_next[DATA_W-1:1];
					cmd_phase_q <= 1'b0;
				end
				else if (byte_done)
				begin
					wr_en_q <= !dir_read_q;
					wr_addr_q <= addr_q;
					wr_data_q <= rx_next;
					addr_q <= addr_q + 7'h01;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Serial transmit
	// -------------------------------------------------------------------------

	// Storage read is one cycle late, so the serial clock must stay below
	// a quarter of clk for the first bit of each byte to be ready in time.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetch_q <= 1'b0;
			fetch_addr_q <= 7'h00;
		end
		else
		begin
			fetch_q <= byte_done && (cmd_phase_q ? rx_next[0] : dir_read_q);
			if (byte_done)
			begin
				fetch_addr_q <= rd_addr_c;
			end
		end
	end

	// Data line driver; the enable drops as soon as select goes high.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_sh_q <= 8'h00;
			serial_data_o <= 1'b0;
			serial_data_oe <= 1'b0;
		end
		else if (select_low)
		begin
			serial_data_oe <= 1'b0;
			serial_data_o <= 1'b0;
		end
		else
		begin
			if (byte_done && cmd_phase_q && rx_next[0])
			begin
				serial_data_oe <= 1'b1;
			end
			if (fetch_q)
			begin
				tx_sh_q <= read_value;
			end
			else if (out_edge && serial_data_oe)
			begin
				serial_data_o <= tx_sh_q[0];
				tx_sh_q <= {1'b0, tx_sh_q[DATA_W-1:1]};
			end
		end
	end

	// -------------------------------------------------------------------------
	// Startup and strap capture
	// -------------------------------------------------------------------------

	// Hold-off counter; the clock input stays off until it expires.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			start_cnt_q <= '0;
			clock_input_enable <= 1'b0;
			power_up_done_flag <= 1'b0;
		end
		else if (start_cnt_q < STARTUP_CNT_W'(STARTUP_CNT - 1))
		begin
			start_cnt_q <= start_cnt_q + 1'b1;
		end
		else
		begin
			clock_input_enable <= 1'b1;
			power_up_done_flag <= 1'b1;
		end
	end

	// The strap is caught on the first edge after release, never in reset.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_done_q <= 1'b0;
			divider_setting <= DIVIDER_RESET;
		end
		else if (!strap_done_q)
		begin
			strap_done_q <= 1'b1;
			divider_setting <= divider_default_pin ? DIVIDER_PIN_HIGH : DIVIDER_PIN_LOW;
		end
		else if (wr_en_q && (wr_addr_q == REG_DIVIDER))
		begin
			divider_setting <= wr_data_q;
		end
	end

	// -------------------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------------------

	// Output enables, configuration and sysref delay registers.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			oe_a_q <= OE_A_RESET;
			oe_b_q <= OE_B_RESET;
			config_q <= CONFIG_RESET;
			sysref_delay <= SYSREF_DELAY_RESET;
		end
		else if (wr_en_q)
		begin
			if (wr_addr_q == REG_OE_A)
			begin
				oe_a_q <= wr_data_q;
			end
			if (wr_addr_q == REG_OE_B)
			begin
				oe_b_q <= wr_data_q;
			end
			if (wr_addr_q == REG_CONFIG)
			begin
				config_q <= wr_data_q;
			end
			if (wr_addr_q == REG_SYSREF_DELAY)
			begin
				sysref_delay <= wr_data_q;
			end
		end
	end

	// Calibration and init launch pulses; command bytes reach only general storage and read back as zero.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bias_cal_start <= 1'b0;
			delay_cal_start <= 1'b0;
			clk_init_start <= 1'b0;
		end
		else
		begin
			bias_cal_start <= cmd_wr && wr_data_q[CMD_BIAS_CAL_BIT];
			delay_cal_start <= cmd_wr && wr_data_q[CMD_DELAY_CAL_BIT];
			clk_init_start <= cmd_wr && wr_data_q[CMD_INIT_CLK_BIT];
		end
	end

	// Init step: outputs are forced low while the dividers resynchronise.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			init_cnt_q <= 8'h00;
		end
		else if (cmd_wr && wr_data_q[CMD_INIT_CLK_BIT])
		begin
			init_cnt_q <= INIT_CYCLES;
		end
		else if (init_cnt_q != 8'h00)
		begin
			init_cnt_q <= init_cnt_q - 8'h01;
		end
	end

	// Gated enables to the output drivers.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clock_output_en <= OE_A_RESET;
			sysref_output_en <= OE_B_RESET;
			outputs_hold_low <= 1'b0;
		end
		else
		begin
			outputs_hold_low <= (init_cnt_q != 8'h00);
			clock_output_en <= (init_cnt_q != 8'h00) ? 8'h00 : oe_a_q;
			sysref_output_en <= (init_cnt_q != 8'h00) ? 8'h00 : oe_b_q;
		end
	end

	// Parking at the crosspoint follows a one-then-zero powerdown pulse in
	// AC-coupled mode and ends when the next sysref edge arrives.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sysref_park_vos <= 1'b0;
		end
		else if (wr_en_q && (wr_addr_q == REG_CONFIG) && config_q[CFG_PD_S_BIT] &&
			!wr_data_q[CFG_PD_S_BIT] && wr_data_q[CFG_BIAS_TYPE_BIT])
		begin
			sysref_park_vos <= 1'b1;
		end
		else if (ref_rise)
		begin
			sysref_park_vos <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// Multi-device alignment
	// -------------------------------------------------------------------------

	// A new command restarts the sequence, so a set never loses to a clear.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			align_state_q <= SCP_ALN_IDLE;
			align_cnt_q <= 8'h00;
			align_pending_flag <= 1'b0;
		end
		else
		begin
			case (align_state_q)
				SCP_ALN_IDLE:
				begin
					align_pending_flag <= 1'b0;
					if (cmd_wr && wr_data_q[CMD_ALIGN_BIT])
					begin
						align_state_q <= SCP_ALN_WAIT;
						align_pending_flag <= 1'b1;
					end
				end
				SCP_ALN_WAIT:
				begin
					align_pending_flag <= 1'b1;
					if (ref_rise)
					begin
						align_state_q <= SCP_ALN_RUN;
						align_cnt_q <= ALIGN_RUN_CYCLES;
					end
				end
				SCP_ALN_RUN:
				begin
					if (cmd_wr && wr_data_q[CMD_ALIGN_BIT])
					begin
						align_state_q <= SCP_ALN_WAIT;
					end
					else if (align_cnt_q == 8'h01)
					begin
						align_state_q <= SCP_ALN_IDLE;
						align_pending_flag <= 1'b0;
					end
					else
					begin
						align_cnt_q <= align_cnt_q - 8'h01;
					end
				end
				default:
				begin
					align_state_q <= SCP_ALN_IDLE;
					align_pending_flag <= 1'b0;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// General register storage
	// -------------------------------------------------------------------------
	scp_regmem u_regmem
	(
		.clk(clk),
		.rst_b(rst_b),
		.wr_en(wr_en_q),
		.wr_addr(wr_addr_q),
		.wr_data(wr_data_q),
		.rd_addr(rd_addr_c),
		.rd_data(mem_rd_data)
	);

endmodule
`default_nettype wire

/* scp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// Serial master on the far side.
// ---------------------------------
module scp_host_model
(
	input wire logic clk,
	input wire logic line,
	output logic select_low,
	output logic sclk,
	output logic host_d,
	output logic host_en,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	logic pol; // Edge on which the port launches read data.
	initial
	begin
		{select_low, sclk, host_d, host_en, rx_valid, rx_data, pol} = {2'b10, 12'h000};
	end
	// Select changes only with the serial clock low; data is released too.
	task automatic sel(input logic lvl);
		@(posedge clk);
		select_low <= lvl;
		host_en <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic xbyte(input logic [7:0] tx, input int nbits, input logic drive);
		logic [7:0] rx;
		rx = 8'h00;
		for (int i = 0; i < nbits; i++)
		begin
			@(posedge clk);
			host_d <= tx[i];
			host_en <= drive;
			repeat (3) @(posedge clk);
			if (!pol)
				rx[i] = line;
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			if (pol)
				rx[i] = line;
			sclk <= 1'b0;
		end
		if (nbits == 8 && !drive)
		begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data <= rx;
			@(posedge clk);
			rx_valid <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* scp_pkg.sv */
// -----------------------------------------------------------------------------
// Shared constants for the serial configuration port.
// -----------------------------------------------------------------------------
package scp_pkg;

	// Register address and data widths.
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Register offsets (7-bit address space).
	localparam logic [6:0] REG_DIVIDER = 7'h10;
	localparam logic [6:0] REG_STATUS = 7'h6e;
	localparam logic [6:0] REG_COMMAND = 7'h70;
	localparam logic [6:0] REG_CONFIG = 7'h71;
	localparam logic [6:0] REG_SYSREF_DELAY = 7'h72;
	localparam logic [6:0] REG_OE_A = 7'h74;
	localparam logic [6:0] REG_OE_B = 7'h76;
	localparam logic [6:0] REG_RESERVED_BASE = 7'h78;

	// Status register fields.
	localparam int ST_ALIGN_BIT = 0;
	localparam int POWER_UP_DONE_FLAG_BIT = 1;

	// Command register fields, all self-clearing.
	localparam int CMD_ALIGN_BIT = 0;
	localparam int CMD_BIAS_CAL_BIT = 1;
	localparam int CMD_DELAY_CAL_BIT = 2;
	localparam int CMD_INIT_CLK_BIT = 3;

	// Configuration register fields.
	localparam int CFG_READ_POL_BIT = 0;
	localparam int CFG_BIAS_TYPE_BIT = 1;
	localparam int CFG_PD_S_BIT = 2;

	// Values after reset.
	localparam logic [7:0] OE_A_RESET = 8'hff;
	localparam logic [7:0] OE_B_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] SYSREF_DELAY_RESET = 8'h00;
	localparam logic [7:0] DIVIDER_RESET = 8'h00;
	localparam logic [7:0] DIVIDER_PIN_LOW = 8'h02;
	localparam logic [7:0] DIVIDER_PIN_HIGH = 8'h01;
	localparam logic [7:0] MEM_RESET = 8'h00;

	// Timing: clock rate and the startup hold-off.
	localparam int CLK_FREQ_HZ = 25000000;
	localparam int STARTUP_TIME_MS = 2;
	localparam int STARTUP_CYCLES = STARTUP_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int STARTUP_CNT_W = 20;

	// Lengths of the internal initialisation and alignment steps.
	localparam logic [7:0] INIT_CYCLES = 8'h10;
	localparam logic [7:0] ALIGN_RUN_CYCLES = 8'h20;

	// Serial bit counter value at the last bit of a byte.
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Alignment sequencer states, Gray coded along idle, wait, run.
	typedef enum logic [1:0] {
		SCP_ALN_IDLE = 2'b00,
		SCP_ALN_WAIT = 2'b01,
		SCP_ALN_RUN = 2'b11
	} scp_align_e;

endpackage

/* scp_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the configuration port.
// ----------------------------------------
module scp_port_chk
#(
	parameter int STARTUP_CNT = 20
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic select_low,
	input wire logic serial_data_oe,
	input wire logic clock_input_enable,
	input wire logic power_up_done_flag,
	input wire logic align_pending_flag,
	input wire logic [scp_pkg::DATA_W-1:0] clock_output_en,
	input wire logic [scp_pkg::DATA_W-1:0] sysref_output_en,
	input wire logic outputs_hold_low,
	input wire logic bias_cal_start,
	input wire logic clk_init_start
);
	import scp_pkg::*;
	// Cycles since reset, saturating so it never wraps.
	int cyc_q;
	// Counts edges after reset release.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cyc_q <= 0;
		else if (cyc_q < STARTUP_CNT)
			cyc_q <= cyc_q + 1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	property p_idle_release;
		select_low [*2] |-> !serial_data_oe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("data line driven");
	property p_ready_pair;
		clock_input_enable == power_up_done_flag;
	endproperty
	a_ready_pair: assert property (p_ready_pair) else $error("ready split");
	property p_ready_keep;
		power_up_done_flag |=> power_up_done_flag;
	endproperty
	a_ready_keep: assert property (p_ready_keep) else $error("ready dropped");
	property p_holdoff;
		(cyc_q + 2 < STARTUP_CNT) |-> !clock_input_enable;
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("clock on early");
	property p_ready_late;
		(cyc_q == STARTUP_CNT) |-> ##[0:8] clock_input_enable;
	endproperty
	a_ready_late: assert property (p_ready_late) else $error("clock on late");
	property p_init_hold;
		clk_init_start |-> ##[0:2] outputs_hold_low;
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("no hold");
	property p_hold_gate;
		outputs_hold_low [*3] |-> clock_output_en == 8'h00 && sysref_output_en == 8'h00;
	endproperty
	a_hold_gate: assert property (p_hold_gate) else $error("outputs not low");
	property p_hold_cause;
		$rose(outputs_hold_low) |-> clk_init_start || $past(clk_init_start) || $past(clk_init_start, 2);
	endproperty
	a_hold_cause: assert property (p_hold_cause) else $error("stray hold");
	property p_cal_pulse;
		bias_cal_start |=> !bias_cal_start;
	endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("long pulse");
	property p_align_min;
		$rose(align_pending_flag) |-> align_pending_flag [*8];
	endproperty
	a_align_min: assert property (p_align_min) else $error("pending short");
	property p_oe_sel;
		$rose(serial_data_oe) |-> !select_low;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("oe unselected");
	c_read: cover property ($rose(serial_data_oe));
	c_init: cover property ($rose(outputs_hold_low));
	c_align: cover property ($fell(align_pending_flag));
endmodule
bind scp_config_port scp_port_chk #(.STARTUP_CNT(STARTUP_CNT)) u_chk (.clk(clk), .rst_b(rst_b),
	.select_low(select_low), .serial_data_oe(serial_data_oe),
	.clock_input_enable(clock_input_enable), .power_up_done_flag(power_up_done_flag),
	.align_pending_flag(align_pending_flag), .clock_output_en(clock_output_en),
	.sysref_output_en(sysref_output_en), .outputs_hold_low(outputs_hold_low),
	.bias_cal_start(bias_cal_start), .clk_init_start(clk_init_start));
`default_nettype wire

/* scp_regmem.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// General register storage with a registered read port.
// -----------------------------------------------------------------------------
module scp_regmem
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [scp_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [scp_pkg::DATA_W-1:0] wr_data,
	input wire logic [scp_pkg::ADDR_W-1:0] rd_addr,
	output logic [scp_pkg::DATA_W-1:0] rd_data
);
	import scp_pkg::*;

	// Storage array; every byte returns to its default at reset.
	logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

	// Write port; the reserved top range is never written.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < (1 << ADDR_W); i++)
			begin
				mem_q[i] <= MEM_RESET;
			end
		end
		else if (wr_en && (wr_addr < REG_RESERVED_BASE))
		begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Read port; data appear one clock after the address.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data <= MEM_RESET;
		end
		else
		begin
			rd_data <= mem_q[rd_addr];
		end
	end

endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import scp_pkg::*;
	logic clk, rst_b, divider_default_pin, sysref_ref_in, tgl_q, line;
	logic select_low, sclk, host_d, host_en, rx_valid, serial_data_o, serial_data_oe;
	logic clock_input_enable, power_up_done_flag, align_pending_flag, outputs_hold_low;
	logic sysref_park_vos, bias_cal_start, delay_cal_start, clk_init_start;
	logic [7:0] rx_data;
	logic [DATA_W-1:0] clock_output_en, sysref_output_en, divider_setting, sysref_delay;
	int fail_count = 0;
	int cmp_count = 0;
	logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
	logic [7:0] wq[$]; // Payload of the next write.
	logic [7:0] d[$];
	logic [31:0] lfsr_q = 32'h8580;
	scp_config_port #(.STARTUP_CNT(20)) uut (.clk(clk), .rst_b(rst_b), .select_low(select_low),
		.sclk(sclk), .serial_data_i(line), .serial_data_o(serial_data_o),
		.serial_data_oe(serial_data_oe), .divider_default_pin(divider_default_pin),
		.sysref_ref_in(sysref_ref_in), .clock_input_enable(clock_input_enable),
		.power_up_done_flag(power_up_done_flag), .align_pending_flag(align_pending_flag),
		.clock_output_en(clock_output_en), .sysref_output_en(sysref_output_en),
		.outputs_hold_low(outputs_hold_low), .sysref_park_vos(sysref_park_vos),
		.bias_cal_start(bias_cal_start), .delay_cal_start(delay_cal_start),
		.clk_init_start(clk_init_start), .divider_setting(divider_setting),
		.sysref_delay(sysref_delay));
	scp_host_model host (.clk(clk), .line(line), .select_low(select_low), .sclk(sclk),
		.host_d(host_d), .host_en(host_en), .rx_valid(rx_valid), .rx_data(rx_data));
	// A released line has no pull, so it shows a toggling pattern.
	assign line = serial_data_oe ? serial_data_o : (host_en ? host_d : tgl_q);
	initial
	begin
		clk = 1'b0;
		tgl_q = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) tgl_q <= ~tgl_q;
	// Counts cycles in which all three launch pulses stand together.
	int pulse_n = 0;
	always @(posedge clk) if (bias_cal_start && delay_cal_start && clk_init_start) pulse_n++;
	// Each read byte is matched against the oldest note.
	always @(posedge clk)
		if (rx_valid === 1'b1)
			chk("read data", rx_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_data);
	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q[7:0];
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("Compared %0d, mismatched %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a);
		host.sel(1'b0);
		host.xbyte({a, 1'b0}, 8, 1'b1);
		foreach (wq[i]) host.xbyte(wq[i], 8, 1'b1);
		host.sel(1'b1);
		wq.delete();
	endtask
	task automatic rd(input logic [6:0] a, input int n);
		host.sel(1'b0);
		host.xbyte({a, 1'b1}, 8, 1'b1);
		repeat (n) host.xbyte(8'h00, 8, 1'b0);
		host.sel(1'b1);
	endtask
	// Bounded wait on ready (0), hold (1) or pending (2).
	task automatic wait_on(input int w, input logic lvl);
		for (int i = 0; i < 300; i++)
		begin
			if ((w == 0 ? power_up_done_flag : w == 1 ? outputs_hold_low : align_pending_flag) === lvl)
				return;
			@(posedge clk);
		end
		fail_count++;
		report_and_stop();
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		{rst_b, divider_default_pin, sysref_ref_in} = 3'b000;
		repeat (4) @(posedge clk);
		chk("clock enables", clock_output_en, 8'hff);
		chk("sysref enables", sysref_output_en, 8'h00);
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk("divider", divider_setting, DIVIDER_PIN_LOW);
		chk("early ready", {7'h00, clock_input_enable}, 8'h00);
		wait_on(0, 1'b1);
		exp_q.push_back(8'h02);
		rd(REG_STATUS, 1);
		// Burst write then burst read, in both read polarities.
		wq = {rnd(), rnd(), rnd()};
		d = wq;
		wr(REG_OE_A);
		repeat (3) @(posedge clk);
		chk("clock enables", clock_output_en, d[0]);
		chk("sysref enables", sysref_output_en, d[2]);
		for (int p = 0; p < 2; p++)
		begin
			wq = {p[7:0]};
			wr(REG_CONFIG);
			host.pol = p[0];
			exp_q = {exp_q, d};
			rd(REG_OE_A, 3);
		end
		wq = {8'h00};
		wr(REG_CONFIG);
		host.pol = 1'b0;
		// Plain storage at the bottom; a read from the top wraps to it.
		wq = {rnd(), rnd()};
		d = wq;
		wr(7'h00); // no reserved writes
		exp_q = {exp_q, 8'h00, d[0]};
		rd(7'h7f, 2);
		// A half byte is dropped when select rises.
		host.sel(1'b0);
		host.xbyte({REG_DIVIDER, 1'b0}, 8, 1'b1);
		host.xbyte(8'h5a, 4, 1'b1);
		host.sel(1'b1);
		chk("divider", divider_setting, DIVIDER_PIN_LOW);
		wq = {rnd()};
		d = wq;
		wr(REG_SYSREF_DELAY);
		repeat (3) @(posedge clk);
		chk("sysref delay", sysref_delay, d[0]);
		// Calibrations and clock init together.
		wq = {8'h0e};
		wr(REG_COMMAND);
		wait_on(1, 1'b1);
		repeat (3) @(posedge clk);
		chk("held enables", clock_output_en, 8'h00);
		wait_on(1, 1'b0);
		chk("launch pulses", 8'(pulse_n), 8'h01);
		exp_q.push_back(8'h00);
		rd(REG_COMMAND, 1);
		// Power-down pulse with AC bias parks the legs.
		wq = {8'h06};
		wr(REG_CONFIG);
		wq = {8'h02};
		wr(REG_CONFIG);
		chk("park", {7'h00, sysref_park_vos}, 8'h01);
		wq = {8'h01};
		wr(REG_COMMAND);
		wait_on(2, 1'b1);
		exp_q.push_back(8'h03);
		rd(REG_STATUS, 1);
		sysref_ref_in <= 1'b1;
		repeat (4) @(posedge clk);
		sysref_ref_in <= 1'b0;
		wait_on(2, 1'b0);
		chk("park", {7'h00, sysref_park_vos}, 8'h00);
		exp_q.push_back(8'h02);
		rd(REG_STATUS, 1);
		// A reset in mid-run with the strap high re-reads the pin.
		rst_b <= 1'b0;
		divider_default_pin <= 1'b1;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk("divider", divider_setting, DIVIDER_PIN_HIGH);
		chk("clock enables", clock_output_en, OE_A_RESET);
		repeat (4) @(posedge clk);
		chk("notes left", 8'(exp_q.size()), 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
